// *** rtl/swip_pkg.sv ***
package swip_pkg;
    localparam int unsigned CLK_PERIOD_NS        = 25;
    localparam int unsigned THROT_INTERVAL_NS    = 1_720_000;
    localparam int unsigned THROT_INTERVAL_CYC   = THROT_INTERVAL_NS / CLK_PERIOD_NS;
    localparam int unsigned NUM_PORTS            = 3;
    localparam int unsigned NUM_CIR              = 24;
    localparam int unsigned CMD_LATENCY          = 2;

    localparam logic [12:0] IDX_BCAST  = 13'h1848;
    localparam logic [12:0] IDX_ADMIT  = 13'h1849;
    localparam logic [12:0] IDX_MCFG   = 13'h184a;
    localparam logic [12:0] IDX_CMD    = 13'h184b;
    localparam logic [12:0] IDX_STS    = 13'h184c;
    localparam logic [12:0] IDX_WDATA  = 13'h184d;
    localparam logic [12:0] IDX_RDATA  = 13'h184e;

    localparam int BT_EN_POS  [3] = '{8, 17, 26};
    localparam int BT_LVL_LSB [3] = '{0, 9, 18};
    localparam int MCFG_EN_BIT     = 0;
    localparam int MCFG_MODE_LSB   = 1;
    localparam int CMD_DIR_BIT     = 7;
    localparam int CMD_SEL_LSB     = 5;
    localparam int CMD_ADDR_LSB    = 0;
    localparam int STS_PEND_BIT    = 0;

    localparam logic [31:0] BT_MASK    = 32'h07ff_ffff;
    localparam logic [31:0] ADMIT_MASK = 32'h0000_0007;
    localparam logic [31:0] MCFG_MASK  = 32'h0000_0007;
    localparam logic [31:0] CMD_MASK   = 32'h0000_00ff;
    localparam logic [31:0] DATA_MASK  = 32'h0000_ffff;
    localparam logic [31:0] BT_RESET   = 32'h0008_0402;
    localparam logic [15:0] BURST_RESET = 16'h0600;
    localparam logic [15:0] CIR_RESET   = 16'h0014;

    typedef enum logic [1:0] {
        MODE_PORT_PRIO,
        MODE_PORT,
        MODE_PRIO,
        MODE_RSVD
    } swip_mode_type;

    typedef enum logic [1:0] {
        SEL_RSVD,
        SEL_CIR,
        SEL_CBS,
        SEL_EBS
    } swip_sel_type;

    function automatic logic [31:0] swip_merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) r[8*b +: 8] = new_v[8*b +: 8];
        end
        return r & mask;
    endfunction

    function automatic logic swip_mapped(input logic [12:0] idx);
        return idx >= IDX_BCAST && idx <= IDX_RDATA;
    endfunction
endpackage

// *** rtl/swip_table_if.sv ***
`timescale 1ns/1ps
interface swip_table_if;
    import swip_pkg::*;
    logic         req;
    logic         rd;
    swip_sel_type sel;
    logic [4:0]   addr;
    logic [15:0]  wdata;
    logic [15:0]  rdata;
    logic         done;
    logic [4:0]   lk_idx;
    logic [15:0]  lk_cir;
    logic [15:0]  cbs;
    logic [15:0]  ebs;
    modport ctrl  (output req, rd, sel, addr, wdata, lk_idx,
                   input rdata, done, lk_cir, cbs, ebs);
    modport store (input req, rd, sel, addr, wdata, lk_idx,
                   output rdata, done, lk_cir, cbs, ebs);
endinterface

// *** rtl/swip_meter_table.sv ***
`timescale 1ns/1ps
module swip_meter_table
    import swip_pkg::*;
(
    input  wire logic   mclk_i,
    input  wire logic   nrst_i,
    swip_table_if.store tbl
);
    logic [15:0] committed_rate_entry [NUM_CIR];
    logic [1:0]  wait_cnt;
    logic        busy;

    // fixed latency mimics the table living in slower shared ram
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            busy     <= 1'b0;
            wait_cnt <= '0;
        end else if (tbl.req && !busy) begin
            busy     <= 1'b1;
            wait_cnt <= 2'(CMD_LATENCY - 1);
        end else if (busy && wait_cnt == '0) begin
            busy <= 1'b0;
        end else if (busy) begin
            wait_cnt <= wait_cnt - 2'd1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < NUM_CIR; i++) committed_rate_entry[i] <= CIR_RESET;
            tbl.cbs   <= BURST_RESET;
            tbl.ebs   <= BURST_RESET;
            tbl.rdata <= '0;
            tbl.done  <= 1'b0;
        end else begin
            tbl.done <= busy && wait_cnt == '0;
            if (busy && wait_cnt == '0) begin
                unique case (tbl.sel)
                    SEL_CIR: begin
                        // out of range entries are dropped, read as zero
                        if (tbl.addr < 5'(NUM_CIR)) begin
                            if (tbl.rd) tbl.rdata <= committed_rate_entry[tbl.addr];
                            else committed_rate_entry[tbl.addr] <= tbl.wdata;
                        end else if (tbl.rd) begin
                            tbl.rdata <= '0;
                        end
                    end
                    SEL_CBS: begin
                        if (tbl.rd) tbl.rdata <= tbl.cbs;
                        else tbl.cbs <= tbl.wdata;
                    end
                    SEL_EBS: begin
                        if (tbl.rd) tbl.rdata <= tbl.ebs;
                        else tbl.ebs <= tbl.wdata;
                    end
                    SEL_RSVD: begin
                        if (tbl.rd) tbl.rdata <= '0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) tbl.lk_cir <= '0;
        else tbl.lk_cir <= (tbl.lk_idx < 5'(NUM_CIR)) ? committed_rate_entry[tbl.lk_idx] : '0;
    end
endmodule

// *** rtl/swip_bcast_throttle.sv ***
`timescale 1ns/1ps
module swip_bcast_throttle
    import swip_pkg::*;
#(
    parameter int unsigned INTERVAL_CYCLES = THROT_INTERVAL_CYC
) (
    input  wire logic                  mclk_i,
    input  wire logic                  nrst_i,
    input  wire logic [2:0]            enable_i,
    input  wire logic [2:0][7:0]       level_i,
    input  wire logic [2:0]            pkt_start_i,
    input  wire logic [2:0][10:0]      pkt_bytes_i,
    output logic      [2:0]            drop_o
);
    logic [16:0]      div_cnt;
    logic             tick;
    logic [2:0][15:0] acc;

    assign tick = div_cnt == 17'(INTERVAL_CYCLES - 1);

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) div_cnt <= '0;
        else if (tick) div_cnt <= '0;
        else div_cnt <= div_cnt + 17'd1;
    end

    // a packet starting on the boundary counts in the new interval
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            acc    <= '0;
            drop_o <= '0;
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                drop_o[p] <= pkt_start_i[p] && enable_i[p] && !tick
                             && acc[p] > {2'b00, level_i[p], 6'b00_0000};
                if (tick) begin
                    acc[p] <= pkt_start_i[p] ? 16'(pkt_bytes_i[p]) : '0;
                end else if (pkt_start_i[p] && enable_i[p]
                             && acc[p] <= {2'b00, level_i[p], 6'b00_0000}) begin
                    // saturate so a long interval cannot wrap back under budget
                    acc[p] <= (acc[p] > 16'hf800) ? 16'hffff
                              : acc[p] + 16'(pkt_bytes_i[p]);
                end
            end
        end
    end
endmodule

// *** rtl/swip_policing_regs.sv ***
`timescale 1ns/1ps
// What this block does
// - per-port broadcast throttle enable at bits 26, 17, 8; reset zero.
// - per-port 8-bit throttle level, 64-byte units per 1.72 ms; reset 02h.
// - per-port bits 2:0 admit packets from non-member ports to active VLANs.
// - metering mode 2:1: port+priority, port, priority, reserved; reset 00.
// - bit 0 enables metering, colouring and dropping; clear at reset.
// - writing the command register starts the indirect table access unless one is pending.
// - command bit 7 picks read (1) or write (0).
// - command bits 6:5 pick table: rate entry, committed or excess burst.
// - command bits 4:0 address one of 24 rate entries.
// - port-only mode: entries 0, 1, 2 serve ports 0, 1, 2.
// - priority-only mode: entry n serves priority n.
// - pending set while an access runs, cleared by hardware when done.
// - table entries are 16 bits; burst sizes reset to 0600h.
// - rate entry means (value+1) x 20 ns per byte; reset 0014h.
module swip_policing_regs
    import swip_pkg::*;
#(
    parameter int unsigned INTERVAL_CYCLES = THROT_INTERVAL_CYC
) (
    input  wire logic              mclk_i,
    input  wire logic              nrst_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [15:0]       s_axi_awaddr_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    output logic      [1:0]        s_axi_bresp_o,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    input  wire logic [15:0]       s_axi_araddr_i,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    output logic      [31:0]       s_axi_rdata_o,
    output logic      [1:0]        s_axi_rresp_o,
    input  wire logic [2:0]        bcast_start_i,
    input  wire logic [2:0][10:0]  bcast_bytes_i,
    output logic      [2:0]        bcast_drop_o,
    output logic      [2:0]        admit_nonmember_o,
    output logic                   meter_enable_o,
    output logic      [1:0]        meter_mode_o,
    input  wire logic [1:0]        lookup_port_i,
    input  wire logic [4:0]        lookup_prio_i,
    output logic      [15:0]       lookup_cir_o,
    output logic      [15:0]       committed_burst_o,
    output logic      [15:0]       excess_burst_o
);
    ////////////////////////////////////////////////////////////////////////////
    logic [31:0]      broadcast_throttle_cfg;
    logic [31:0]      nonmember_admit_cfg;
    logic [31:0]      ingress_meter_cfg;
    logic [31:0]      ingress_meter_table_cmd;
    logic [31:0]      meter_write_value;
    logic [31:0]      meter_read_value;
    logic             cmd_pending;
    logic             aw_held;
    logic             w_held;
    logic [12:0]      aw_idx;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             do_write;
    logic             ar_take;
    logic [12:0]      ar_idx;
    logic [31:0]      next_rdata;
    logic [2:0]       bt_enable;
    logic [2:0][7:0]  bt_level;
    logic [4:0]       next_lk_idx;
    swip_mode_type    cur_mode;

    swip_table_if tbl_if ();

    ////////////////////////////////////////////////////////////////////////////
    // write channel: address and data taken in either order
    assign do_write = aw_held && w_held && !s_axi_bvalid_o;
    assign ar_take  = s_axi_arvalid_i && s_axi_arready_o;
    assign ar_idx   = s_axi_araddr_i[14:2];

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            s_axi_awready_o <= 1'b1;
            aw_held         <= 1'b0;
            aw_idx          <= '0;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            s_axi_awready_o <= 1'b0;
            aw_held         <= 1'b1;
            aw_idx          <= s_axi_awaddr_i[15] ? 13'h0000 : s_axi_awaddr_i[14:2];
        end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_awready_o <= 1'b1;
            aw_held         <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            s_axi_wready_o <= 1'b1;
            w_held         <= 1'b0;
            w_data         <= '0;
            w_strb         <= '0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            s_axi_wready_o <= 1'b0;
            w_held         <= 1'b1;
            w_data         <= s_axi_wdata_i;
            w_strb         <= s_axi_wstrb_i;
        end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_wready_o <= 1'b1;
            w_held         <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= 2'h0;
        end else if (do_write) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= swip_mapped(aw_idx) ? 2'h0 : 2'h2;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers; masks keep reserved bits at zero
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            broadcast_throttle_cfg <= BT_RESET;
            nonmember_admit_cfg    <= '0;
            ingress_meter_cfg      <= '0;
            meter_write_value      <= '0;
        end else if (do_write) begin
            unique case (aw_idx)
                IDX_BCAST: broadcast_throttle_cfg <= swip_merge(broadcast_throttle_cfg,
                               w_data, w_strb, BT_MASK);
                IDX_ADMIT: nonmember_admit_cfg <= swip_merge(nonmember_admit_cfg,
                               w_data, w_strb, ADMIT_MASK);
                IDX_MCFG:  ingress_meter_cfg <= swip_merge(ingress_meter_cfg,
                               w_data, w_strb, MCFG_MASK);
                IDX_WDATA: meter_write_value <= swip_merge(meter_write_value,
                               w_data, w_strb, DATA_MASK);
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // indirect command; a command written while one is pending is dropped
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            ingress_meter_table_cmd <= '0;
            cmd_pending             <= 1'b0;
            tbl_if.req              <= 1'b0;
        end else begin
            tbl_if.req <= 1'b0;
            if (do_write && aw_idx == IDX_CMD && !cmd_pending) begin
                ingress_meter_table_cmd <= swip_merge(ingress_meter_table_cmd,
                                           w_data, w_strb, CMD_MASK);
                cmd_pending             <= 1'b1;
                tbl_if.req              <= 1'b1;
            end else if (tbl_if.done) begin
                cmd_pending <= 1'b0;
            end
        end
    end

    assign tbl_if.rd    = ingress_meter_table_cmd[CMD_DIR_BIT];
    assign tbl_if.sel   = swip_sel_type'(ingress_meter_table_cmd[CMD_SEL_LSB +: 2]);
    assign tbl_if.addr  = ingress_meter_table_cmd[CMD_ADDR_LSB +: 5];
    assign tbl_if.wdata = meter_write_value[15:0];

    // result register only moves on a completed read
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) meter_read_value <= '0;
        else if (tbl_if.done && tbl_if.rd) meter_read_value <= {16'h0000, tbl_if.rdata};
    end

    ////////////////////////////////////////////////////////////////////////////
    // read channel
    always_comb begin
        next_rdata = '0;
        if (!s_axi_araddr_i[15]) begin
            unique case (ar_idx)
                IDX_BCAST: next_rdata = broadcast_throttle_cfg;
                IDX_ADMIT: next_rdata = nonmember_admit_cfg;
                IDX_MCFG:  next_rdata = ingress_meter_cfg;
                IDX_CMD:   next_rdata = ingress_meter_table_cmd;
                IDX_STS:   next_rdata = {31'h0000_0000, cmd_pending};
                IDX_WDATA: next_rdata = meter_write_value;
                IDX_RDATA: next_rdata = meter_read_value;
                default:   next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= '0;
            s_axi_rresp_o   <= 2'h0;
        end else if (ar_take) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            s_axi_rdata_o   <= next_rdata;
            s_axi_rresp_o   <= (!s_axi_araddr_i[15] && swip_mapped(ar_idx)) ? 2'h0 : 2'h2;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration outputs, registered once more to stay flop-driven
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            admit_nonmember_o <= '0;
            meter_enable_o    <= 1'b0;
            meter_mode_o      <= '0;
        end else begin
            admit_nonmember_o <= nonmember_admit_cfg[2:0];
            meter_enable_o    <= ingress_meter_cfg[MCFG_EN_BIT];
            meter_mode_o      <= ingress_meter_cfg[MCFG_MODE_LSB +: 2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // rate entry selection; reserved mode and metering off both use entry 0
    assign cur_mode = swip_mode_type'(ingress_meter_cfg[MCFG_MODE_LSB +: 2]);

    always_comb begin
        next_lk_idx = '0;
        if (ingress_meter_cfg[MCFG_EN_BIT]) begin
            unique case (cur_mode)
                MODE_PORT_PRIO: next_lk_idx = {lookup_port_i, lookup_prio_i[2:0]};
                MODE_PORT:      next_lk_idx = {3'b000, lookup_port_i};
                MODE_PRIO:      next_lk_idx = lookup_prio_i;
                MODE_RSVD:      next_lk_idx = '0;
            endcase
        end
    end

    assign tbl_if.lk_idx = next_lk_idx;

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            lookup_cir_o      <= CIR_RESET;
            committed_burst_o <= BURST_RESET;
            excess_burst_o    <= BURST_RESET;
        end else begin
            lookup_cir_o      <= tbl_if.lk_cir;
            committed_burst_o <= tbl_if.cbs;
            excess_burst_o    <= tbl_if.ebs;
        end
    end

    swip_meter_table u_table (
        .mclk_i (mclk_i),
        .nrst_i (nrst_i),
        .tbl    (tbl_if)
    );

    ////////////////////////////////////////////////////////////////////////////
    // broadcast throttling
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            bt_enable[p] = broadcast_throttle_cfg[BT_EN_POS[p]];
            bt_level[p]  = broadcast_throttle_cfg[BT_LVL_LSB[p] +: 8];
        end
    end

    swip_bcast_throttle #(
        .INTERVAL_CYCLES (INTERVAL_CYCLES)
    ) u_throttle (
        .mclk_i      (mclk_i),
        .nrst_i      (nrst_i),
        .enable_i    (bt_enable),
        .level_i     (bt_level),
        .pkt_start_i (bcast_start_i),
        .pkt_bytes_i (bcast_bytes_i),
        .drop_o      (bcast_drop_o)
    );
endmodule

// *** verif/swip_policing_regs_chk.sv ***
`timescale 1ns/1ps
module swip_policing_regs_chk (
    input wire logic        mclk_i,
    input wire logic        nrst_i,
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_wready_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [2:0]  bcast_start_i,
    input wire logic [2:0]  bcast_drop_o,
    input wire logic [2:0]  admit_nonmember_o,
    input wire logic        meter_enable_o,
    input wire logic [1:0]  meter_mode_o,
    input wire logic [15:0] committed_burst_o,
    input wire logic [15:0] excess_burst_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    ////////////////////////////////////////////////////////////////////////////////
    // cycles since last write response; saturates so old writes never excuse a change
    logic [3:0] since_b;
    always_ff @(posedge mclk_i) begin
        if (!nrst_i)
            since_b <= 4'hf;
        else if (s_axi_bvalid_o)
            since_b <= 4'h0;
        else if (since_b != 4'hf)
            since_b <= since_b + 4'h1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_mode; !$stable(meter_mode_o) |-> since_b <= 4'h2; endproperty
    a_mode: assert property (p_mode) else $error("mode moved without write");
    property p_en; !$stable(meter_enable_o) |-> since_b <= 4'h2; endproperty
    a_en: assert property (p_en) else $error("enable moved without write");
    property p_admit; !$stable(admit_nonmember_o) |-> since_b <= 4'h2; endproperty
    a_admit: assert property (p_admit) else $error("admit moved without write");
    property p_burst;
        !$stable({committed_burst_o, excess_burst_o}) |-> since_b <= 4'h8;
    endproperty
    a_burst: assert property (p_burst) else $error("burst moved without command");
    property p_drop; (bcast_drop_o & ~$past(bcast_start_i)) == 3'b000; endproperty
    a_drop: assert property (p_drop) else $error("drop without packet start");
    property p_bhold; s_axi_bvalid_o |=> s_axi_bvalid_o != $past(s_axi_bready_i); endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_busy; s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o; endproperty
    a_busy: assert property (p_busy) else $error("write accepted during response");
    property p_rhold;
        s_axi_rvalid_o |=> (s_axi_rvalid_o != $past(s_axi_rready_i))
            && (!s_axi_rvalid_o || $stable(s_axi_rdata_o));
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data not held");
endmodule

bind swip_policing_regs swip_policing_regs_chk i_swip_policing_regs_chk (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i), .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i), .s_axi_rdata_o(s_axi_rdata_o),
    .bcast_start_i(bcast_start_i), .bcast_drop_o(bcast_drop_o),
    .admit_nonmember_o(admit_nonmember_o), .meter_enable_o(meter_enable_o),
    .meter_mode_o(meter_mode_o), .committed_burst_o(committed_burst_o),
    .excess_burst_o(excess_burst_o));

// *** verif/swip_policing_regs_tb.sv ***
`timescale 1ns/1ps
module swip_policing_regs_tb;
    logic mclk_i = 1'b0, nrst_i = 1'b0, awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0;
    logic rrd = 1'b0, awr, wr_rdy, bv, arr, rv, men;
    logic [15:0] awa = '0, ara = '0, committed_rate_entry, cbs, ebs;
    logic [31:0] wd = '0, rdat, v;
    logic [1:0] bres, rres, r, mode, port = 2'h0;
    logic [2:0] start = 3'h0, drop, admit;
    logic [2:0][10:0] nb = '0;
    logic [4:0] prio = 5'h00;
    int bad_count = 0, checks_done = 0;
    logic [15:0] adr [4] = '{16'h6120, 16'h6124, 16'h6128, 16'h6130};
    logic [31:0] rst [4] = '{32'h0008_0402, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    logic [31:0] msk [4] = '{32'h07ff_ffff, 32'h0000_0007, 32'h0000_0007, 32'h0000_0000};
    logic [31:0] cfgv [3] = '{32'h0000_0001, 32'h0000_0003, 32'h0000_0005};
    logic [4:0] prv [3] = '{5'h02, 5'h02, 5'h0a};
    logic [15:0] expv [3] = '{16'h00aa, 16'h00bb, 16'h00aa};

    always #12.5 mclk_i = ~mclk_i;

    // short interval keeps the throttle test inside the run budget
    swip_policing_regs #(.INTERVAL_CYCLES(200)) i_swip_policing_regs (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
        .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_rdy),
        .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(brd), .s_axi_bresp_o(bres), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(rrd), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rres),
        .bcast_start_i(start), .bcast_bytes_i(nb), .bcast_drop_o(drop),
        .admit_nonmember_o(admit), .meter_enable_o(men), .meter_mode_o(mode),
        .lookup_port_i(port), .lookup_prio_i(prio), .lookup_cir_o(committed_rate_entry),
        .committed_burst_o(cbs), .excess_burst_o(ebs));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic close_out();
        if (bad_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ready raised with the request; only the watchdog ends a hung wait
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        brd <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (awv && awr)
                awv <= 1'b0;
            if (wv && wr_rdy)
                wv <= 1'b0;
        end while (!bv);
        brd <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] rs);
        @(posedge mclk_i);
        ara <= a;
        arv <= 1'b1;
        rrd <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (arv && arr)
                arv <= 1'b0;
        end while (!rv);
        d = rdat;
        rs = rres;
        rrd <= 1'b0;
    endtask

    // write value first, then command, then poll pending
    task automatic tcmd(input logic [7:0] c, input logic [15:0] d);
        int n;
        n = 0;
        wr(16'h6134, {16'h0000, d});
        wr(16'h612c, {24'h00_0000, c});
        do begin
            rd(16'h6130, v, r);
            n++;
        end while (v[0] !== 1'b0 && n < 50);
        chk("pending", 32'h0000_0000, v);
        chk("pend_set", 32'h0000_0001, {31'h0, n > 1});
    endtask

    task automatic pkt(input logic e);
        @(posedge mclk_i);
        start <= 3'b001;
        nb[0] <= 11'd40;
        @(posedge mclk_i);
        start <= 3'b000;
        @(negedge mclk_i);
        chk("drop", {31'h0, e}, {29'h0, drop});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge mclk_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(adr[i], v, r);
            chk("reset", rst[i], v);
            wr(adr[i], 32'hffff_ffff);
            rd(adr[i], v, r);
            chk("mask", msk[i], v);
        end
        chk("outs", 32'h0000_003f, {26'h0, admit, men, mode});
        rd(16'h6140, v, r);
        chk("unmapped", 32'h0000_0002, {30'h0, r});
        wr(16'h6140, 32'h0000_0000);
        chk("bresp", 32'h0000_0002, {30'h0, bres});
        tcmd(8'ha5, 16'h0000);
        rd(16'h6138, v, r);
        chk("cir_rst", 32'h0000_0014, v);
        for (int i = 0; i < 2; i++) begin
            tcmd(8'hc0 | (i == 1 ? 8'h20 : 8'h00), 16'h0000);
            rd(16'h6138, v, r);
            chk("burst_rst", 32'h0000_0600, v);
        end
        tcmd(8'h40, 16'h0123);
        tcmd(8'h60, 16'h0456);
        chk("bursts", 32'h0123_0456, {cbs, ebs});
        tcmd(8'h37, 16'h1234);
        tcmd(8'hb7, 16'h0000);
        rd(16'h6138, v, r);
        chk("cir_rw", 32'h0000_1234, v);
        tcmd(8'h2a, 16'h00aa);
        tcmd(8'h21, 16'h00bb);
        for (int i = 0; i < 3; i++) begin
            wr(16'h6128, cfgv[i]);
            prio <= prv[i];
            port <= 2'h1;
            repeat (4) @(posedge mclk_i);
            chk("lookup", {16'h0000, expv[i]}, {16'h0000, committed_rate_entry});
        end
        wr(16'h6120, 32'h0000_0101);
        pkt(1'b0);
        pkt(1'b0);
        pkt(1'b1);
        repeat (200) @(posedge mclk_i);
        pkt(1'b0);
        close_out();
    end

    initial begin
        repeat (20000) @(posedge mclk_i);
        bad_count++;
        close_out();
    end
endmodule
